//--- verilog/sipo_pkg.sv
package sipo_pkg;
  localparam int SIPO_WIDTH = 8;
  localparam logic [SIPO_WIDTH-1:0] SIPO_ZERO = 8'h00;
  localparam int SIPO_FIRST = 0;
  localparam int SIPO_LAST = SIPO_WIDTH - 1;
  localparam logic [1:0] SIPO_SYNC_ZERO = 2'h0;

  typedef struct packed {
    logic data;
    logic clock;
    logic store;
    logic clear_n;
    logic enable_n;
  } sipo_pins_type;
endpackage

//--- verilog/sipo_sync.sv
`timescale 1ns/1ps
module sipo_sync
  import sipo_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic [1:0] sync_r;
  logic [1:0] sync_nxt;

  always_comb begin
    sync_nxt = {sync_r[0], din};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_r <= SIPO_SYNC_ZERO;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign dout = sync_r[1];
endmodule

//--- verilog/sipo_latch.sv
`timescale 1ns/1ps
module sipo_latch
  import sipo_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SHIFT_DATA_IN,
  input wire logic SHIFT_CLOCK,
  input wire logic STORE_CLOCK,
  input wire logic SHIFT_CLEAR_N,
  input wire logic OUT_ENABLE_N,
  output logic [SIPO_WIDTH-1:0] PARALLEL_OUT,
  output logic [SIPO_WIDTH-1:0] PARALLEL_OE,
  output logic CASCADE_OUT
);
  // pins are sampled on CLK; both pin clocks must stay high and low two CLK periods or more
  sipo_pins_type raw;
  sipo_pins_type pin;
  logic sclk_d_r;
  logic sclk_d_nxt;
  logic rclk_d_r;
  logic rclk_d_nxt;
  logic [SIPO_WIDTH-1:0] shift_r;
  logic [SIPO_WIDTH-1:0] shift_nxt;
  logic [SIPO_WIDTH-1:0] store_r;
  logic [SIPO_WIDTH-1:0] store_nxt;
  logic shift_rise;
  logic store_rise;

  assign raw = '{data: SHIFT_DATA_IN, clock: SHIFT_CLOCK, store: STORE_CLOCK,
                 clear_n: SHIFT_CLEAR_N, enable_n: OUT_ENABLE_N};

  for (genvar i = 0; i < $bits(sipo_pins_type); i++) begin : g_sync
    sipo_sync u_sync (
      .clk(CLK),
      .nrst(NRST),
      .din(raw[i]),
      .dout(pin[i])
    );
  end

  // data and clock share one sync depth so setup before the edge is kept
  assign shift_rise = pin.clock && !sclk_d_r;
  assign store_rise = pin.store && !rclk_d_r;

  always_comb begin
    sclk_d_nxt = pin.clock;
    rclk_d_nxt = pin.store;
    shift_nxt = shift_r;
    store_nxt = store_r;
    if (!pin.clear_n) begin
      shift_nxt = SIPO_ZERO;
    end else if (shift_rise) begin
      shift_nxt = {shift_r[SIPO_LAST-1:SIPO_FIRST], pin.data};
    end
    // storage copies the pre-edge shift value; clear does not reach it
    if (store_rise) begin
      store_nxt = shift_r;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
      shift_r <= SIPO_ZERO;
      store_r <= SIPO_ZERO;
    end else begin
      sclk_d_r <= sclk_d_nxt;
      rclk_d_r <= rclk_d_nxt;
      shift_r <= shift_nxt;
      store_r <= store_nxt;
    end
  end

  assign CASCADE_OUT = shift_r[SIPO_LAST];
  assign PARALLEL_OUT = store_r;
  // enable only gates the drivers, never the registers
  assign PARALLEL_OE = {SIPO_WIDTH{!pin.enable_n}};

  AST_CLEAR_ZERO: assert property (@(posedge CLK) disable iff (!NRST)
    !pin.clear_n |=> shift_r == SIPO_ZERO)
    else $error("shift register not cleared");

  AST_SHIFT_IN: assert property (@(posedge CLK) disable iff (!NRST)
    pin.clear_n && shift_rise |=> shift_r[SIPO_FIRST] == $past(pin.data))
    else $error("serial bit not taken in");

  AST_SHIFT_ON: assert property (@(posedge CLK) disable iff (!NRST)
    pin.clear_n && shift_rise |=>
      shift_r[SIPO_LAST:1] == $past(shift_r[SIPO_LAST-1:SIPO_FIRST]))
    else $error("stages did not advance");

  AST_SHIFT_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
    pin.clear_n && !shift_rise |=> $stable(shift_r))
    else $error("shift register moved without shift clock");

  AST_STORE_LOAD: assert property (@(posedge CLK) disable iff (!NRST)
    store_rise |=> PARALLEL_OUT == $past(shift_r))
    else $error("storage did not load");

  AST_STORE_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
    !store_rise |=> $stable(store_r))
    else $error("storage changed without storage clock");

  // named steps of a shift, a store and a clear, reused by the properties below
  sequence seq_shift_step;
    pin.clear_n && shift_rise;
  endsequence

  sequence seq_store_step;
    store_rise;
  endsequence

  sequence seq_clear_step;
    !pin.clear_n;
  endsequence

  AST_CASCADE: assert property (@(posedge CLK) disable iff (!NRST)
    seq_shift_step |=> CASCADE_OUT == $past(shift_r[SIPO_LAST-1]))
    else $error("cascade output did not take the stage before it");

  AST_OE_FOLLOW: assert property (@(posedge CLK) disable iff (!NRST)
    !pin.enable_n |-> PARALLEL_OE == {SIPO_WIDTH{1'b1}})
    else $error("outputs not driven when enabled");

  AST_OE_OFF: assert property (@(posedge CLK) disable iff (!NRST)
    pin.enable_n |-> PARALLEL_OE == SIPO_ZERO)
    else $error("outputs driven while disabled");

  AST_SHIFT_ONCE: assert property (@(posedge CLK) disable iff (!NRST)
    shift_rise |=> !shift_rise)
    else $error("one shift clock rise seen twice");

  AST_STORE_ONCE: assert property (@(posedge CLK) disable iff (!NRST)
    store_rise |=> !store_rise)
    else $error("one storage clock rise seen twice");

  // clear wins over a shift rise in the same cycle
  AST_CLEAR_WINS: assert property (@(posedge CLK) disable iff (!NRST)
    seq_clear_step and shift_rise |=> shift_r == SIPO_ZERO)
    else $error("shift rise beat the clear");

  // a clear alone must leave the stored outputs where they were
  AST_CLEAR_KEEPS_STORE: assert property (@(posedge CLK) disable iff (!NRST)
    !pin.clear_n && !store_rise |=> $stable(store_r))
    else $error("clear reached the storage register");

  AST_STORE_AFTER_CLEAR: assert property (@(posedge CLK) disable iff (!NRST)
    seq_clear_step ##1 (seq_clear_step and seq_store_step) |=> PARALLEL_OUT == SIPO_ZERO)
    else $error("storage did not load the cleared contents");

  // shifting alone must not disturb what the outputs show
  AST_SHIFT_NO_STORE: assert property (@(posedge CLK) disable iff (!NRST)
    seq_shift_step and !store_rise |=> $stable(PARALLEL_OUT))
    else $error("shift disturbed the stored outputs");

  AST_PAR_OUT: assert property (@(posedge CLK) disable iff (!NRST)
    seq_store_step ##1 !store_rise |=> $stable(PARALLEL_OUT))
    else $error("parallel outputs drifted after a load");

  AST_OE_NO_TOUCH: assert property (@(posedge CLK) disable iff (!NRST)
    $changed(pin.enable_n) && pin.clear_n && !shift_rise && !store_rise
      |=> $stable(shift_r) && $stable(store_r))
    else $error("enable toggle disturbed registers");
endmodule

//--- verification/sipo_host.sv
`timescale 1ns/1ps
module sipo_host
  import sipo_pkg::*;
(
  input wire logic clk,
  output sipo_pins_type pins
);
  initial pins = 5'b00011;
  // clock, store and clear_n each get their own pulse, so shifting never touches the store pin
  task automatic pulse(input int w, input logic d, input int hold);
    @(negedge clk);
    pins.data = d;
    pins.clock = (w == 0);
    pins.store = (w == 1);
    pins.clear_n = (w != 2);
    repeat (hold) @(negedge clk);
    pins.clock = 1'b0;
    pins.store = 1'b0;
    pins.clear_n = 1'b1;
    // a released data line must not keep showing the old bit
    pins.data = ~d;
    repeat (hold) @(negedge clk);
  endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  import sipo_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [SIPO_WIDTH-1:0] pout;
  logic [SIPO_WIDTH-1:0] poe;
  logic cout;
  sipo_pins_type pins;
  int mismatches = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'ha605;
  logic [7:0] sh = 8'h00;
  logic [7:0] st = 8'h00;
  logic [7:0] b;
  always #25 clk = ~clk;
  sipo_host u_host (.clk(clk), .pins(pins));
  sipo_latch u_dut (.CLK(clk), .NRST(nrst), .SHIFT_DATA_IN(pins.data),
    .SHIFT_CLOCK(pins.clock), .STORE_CLOCK(pins.store), .SHIFT_CLEAR_N(pins.clear_n),
    .OUT_ENABLE_N(pins.enable_n), .PARALLEL_OUT(pout), .PARALLEL_OE(poe),
    .CASCADE_OUT(cout));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      b = (i == 0) ? 8'hff : seed[7:0];
      for (int k = 0; k < 8; k++) begin
        u_host.pulse(0, b[7-k], 2 + seed[k]);
        sh = {sh[6:0], b[7-k]};
        check("cascade", {7'h00, cout}, {7'h00, sh[7]});
      end
      check("held", pout, st);
      u_host.pins.enable_n = seed[9];
      repeat (3) @(negedge clk);
      check("enable", poe, seed[9] ? 8'h00 : 8'hff);
      check("oe keeps", pout, st);
      if (seed[8]) begin
        u_host.pulse(2, seed[11], 3);
        sh = 8'h00;
        check("cleared", {7'h00, cout}, 8'h00);
        check("kept", pout, st);
      end
      u_host.pulse(1, seed[10], 2);
      st = sh;
      check("stored", pout, st);
    end
    final_report();
  end
  initial begin
    #(50 * 20000);
    mismatches++;
    final_report();
  end
endmodule
